// file: ibh_pkg.sv
// Shared constants and types for the instrument bus handshake ends.
package ibh_pkg;
  localparam int unsigned CLK_HZ             = 50_000_000;
  localparam int unsigned CLK_NS             = 1_000_000_000 / CLK_HZ;
  // Source settling times, in nanoseconds as specified.
  localparam int unsigned SETTLE_OPEN_NS     = 2000;
  localparam int unsigned SETTLE_TRI_NS      = 1100;
  localparam int unsigned SETTLE_TRI_ATN_NS  = 700;
  localparam int unsigned SETTLE_FAST_NS     = 500;
  // Response limits, in nanoseconds.
  localparam int unsigned ATN_RESP_NS        = 200;
  localparam int unsigned IFC_RESP_NS        = 100_000;
  // Least times round up, longest times round down.
  localparam int unsigned SETTLE_OPEN_CYC    = (SETTLE_OPEN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SETTLE_TRI_CYC     = (SETTLE_TRI_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SETTLE_TRI_ATN_CYC = (SETTLE_TRI_ATN_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned SETTLE_FAST_CYC    = (SETTLE_FAST_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned ATN_RESP_CYC       = ATN_RESP_NS / CLK_NS;
  localparam int unsigned IFC_RESP_CYC       = IFC_RESP_NS / CLK_NS;
  localparam int unsigned SETTLE_W           = 8;
  // Address byte layout on the data lines.
  localparam int unsigned ADDR_LSB           = 0;
  localparam int unsigned ADDR_W             = 5;
  localparam logic [2:0]  GRP_LISTEN         = 3'h1;
  localparam logic [2:0]  GRP_TALK           = 3'h2;
  localparam logic [4:0]  ADDR_UN            = 5'h1F;
  // Driver kind selects the settling time.
  typedef enum logic [1:0] {IBH_DRV_OPEN, IBH_DRV_TRI, IBH_DRV_TRI_ATN} ibh_drv_e;
endpackage

// file: ibh_if.sv
// Instrument bus wires joining the device end and the controller end.
`timescale 1ns/100ps
`default_nettype none
interface ibh_if;
  // Positive-logic handshake and management wires, each end's output and enable.
  logic [7:0] dev_data_o;
  logic       dev_data_oe;
  logic       dev_valid_o;
  logic       dev_ready_o;
  logic       dev_accepted_o;
  logic       dev_eoi_o;
  logic [7:0] ctl_data_o;
  logic       ctl_data_oe;
  logic       ctl_valid_o;
  logic       ctl_ready_o;
  logic       ctl_accepted_o;
  logic       ctl_atn_o;
  logic       ctl_eoi_o;
  logic       ctl_ifc_o;
  logic       ctl_ren_o;
  // Resolved bus: data wire-ORs, ready and accepted wire-AND.
  logic [7:0] bus_data;
  logic       bus_valid;
  logic       bus_ready;
  logic       bus_accepted;
  logic       bus_eoi;
  assign bus_data     = (dev_data_oe ? dev_data_o : 8'h00) | (ctl_data_oe ? ctl_data_o : 8'h00);
  assign bus_valid    = dev_valid_o | ctl_valid_o;
  assign bus_ready    = dev_ready_o & ctl_ready_o;
  assign bus_accepted = dev_accepted_o & ctl_accepted_o;
  assign bus_eoi      = dev_eoi_o | ctl_eoi_o;
  modport device (
    output dev_data_o, dev_data_oe, dev_valid_o, dev_ready_o, dev_accepted_o, dev_eoi_o,
    input  bus_data, bus_valid, bus_ready, bus_accepted, bus_eoi,
    input  ctl_atn_o, ctl_ifc_o, ctl_ren_o
  );
  modport controller (
    output ctl_data_o, ctl_data_oe, ctl_valid_o, ctl_ready_o, ctl_accepted_o,
    output ctl_atn_o, ctl_eoi_o, ctl_ifc_o, ctl_ren_o,
    input  bus_data, bus_valid, bus_ready, bus_accepted
  );
endinterface
`default_nettype wire

// file: ibh_controller.sv
// Controller end: sends commands under attention and moves data bytes.
`timescale 1ns/100ps
`default_nettype none
module ibh_ctl
  import ibh_pkg::*;
(
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       rst_n,
  // Bus
  ibh_if.controller       bus,
  // Send request
  input  wire logic       send_req,
  input  wire logic [7:0] send_byte,
  input  wire logic       send_atn,
  input  wire logic       send_eoi,
  output logic            send_busy,
  // Receive
  input  wire logic       rx_enable,
  output logic [7:0]      rx_byte,
  output logic            rx_strobe,
  // Management
  input  wire logic       ifc_level,
  input  wire logic       ren_level,
  input  wire logic       poll_req,
  output logic [7:0]      poll_byte,
  output logic            poll_done
);
  typedef enum logic [2:0] {IBH_C_IDLE, IBH_C_SETTLE, IBH_C_VALID, IBH_C_HOLD,
                            IBH_C_POLL} ibh_cst_e;
  ibh_cst_e          st_r;
  logic [SETTLE_W-1:0] cnt_r;
  logic [7:0]        data_r;
  logic              atn_r, eoi_r, oe_r, valid_r, rdy_r, acc_r, rx_st_r;
  logic [7:0]        rx_r, poll_r;
  logic              pdone_r, ifc_r, ren_r;
  logic [1:0]        ah_r;
  wire               settled = (cnt_r == SETTLE_W'(SETTLE_OPEN_CYC - 1));
  wire               pwait   = (cnt_r == SETTLE_W'(ATN_RESP_CYC + 1));
  wire               listen_on = rx_enable & ~oe_r;
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= IBH_C_IDLE;
      cnt_r <= '0;
      data_r <= 8'h00;
      atn_r <= 1'b0;
      eoi_r <= 1'b0;
      oe_r <= 1'b0;
      valid_r <= 1'b0;
      pdone_r <= 1'b0;
      poll_r <= 8'h00;
    end
    else
    begin
      pdone_r <= 1'b0;
      unique case (st_r)
        IBH_C_IDLE:
        begin
          cnt_r <= '0;
          if (poll_req)
          begin
            atn_r <= 1'b1;
            eoi_r <= 1'b1;
            st_r <= IBH_C_POLL;
          end
          else if (send_req)
          begin
            data_r <= send_byte;
            atn_r <= send_atn;
            eoi_r <= send_eoi;
            oe_r <= 1'b1;
            st_r <= IBH_C_SETTLE;
          end
        end
        IBH_C_SETTLE:
        begin
          cnt_r <= cnt_r + 1'b1;
          if (settled && bus.bus_ready && !bus.bus_accepted)
          begin
            valid_r <= 1'b1;
            st_r <= IBH_C_VALID;
          end
        end
        IBH_C_VALID:
          if (bus.bus_accepted)
          begin
            valid_r <= 1'b0;
            st_r <= IBH_C_HOLD;
          end
        IBH_C_HOLD:
          if (!bus.bus_accepted || bus.bus_ready)
          begin
            // Attention is let go after each byte, or an addressed talker could never start.
            atn_r <= 1'b0;
            oe_r <= 1'b0;
            eoi_r <= 1'b0;
            st_r <= IBH_C_IDLE;
          end
        IBH_C_POLL:
        begin
          cnt_r <= cnt_r + 1'b1;
          if (pwait)
          begin
            poll_r <= bus.bus_data;
            pdone_r <= 1'b1;
            atn_r <= 1'b0;
            eoi_r <= 1'b0;
            st_r <= IBH_C_IDLE;
          end
        end
      endcase
    end
  end
  // Acceptor side used when the controller listens to a talker.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ah_r <= 2'd0;
      rdy_r <= 1'b1;
      acc_r <= 1'b1;
      rx_r <= 8'h00;
      rx_st_r <= 1'b0;
      ifc_r <= 1'b0;
      ren_r <= 1'b0;
    end
    else
    begin
      ifc_r <= ifc_level;
      ren_r <= ren_level;
      rx_st_r <= 1'b0;
      if (!listen_on)
      begin
        ah_r <= 2'd0;
        rdy_r <= 1'b1;
        acc_r <= 1'b1;
      end
      else if (ah_r == 2'd0)
      begin
        rdy_r <= 1'b1;
        acc_r <= 1'b0;
        ah_r <= 2'd1;
      end
      else if (ah_r == 2'd1 && bus.bus_valid)
      begin
        rx_r <= bus.bus_data;
        rx_st_r <= 1'b1;
        rdy_r <= 1'b0;
        acc_r <= 1'b1;
        ah_r <= 2'd2;
      end
      else if (ah_r == 2'd2 && !bus.bus_valid)
        ah_r <= 2'd0;
    end
  end
  assign bus.ctl_data_o     = data_r;
  assign bus.ctl_data_oe    = oe_r;
  assign bus.ctl_valid_o    = valid_r;
  assign bus.ctl_ready_o    = rdy_r;
  assign bus.ctl_accepted_o = acc_r;
  assign bus.ctl_atn_o      = atn_r;
  assign bus.ctl_eoi_o      = eoi_r;
  assign bus.ctl_ifc_o      = ifc_r;
  assign bus.ctl_ren_o      = ren_r;
  assign send_busy = (st_r != IBH_C_IDLE);
  assign rx_byte   = rx_r;
  assign rx_strobe = rx_st_r;
  assign poll_byte = poll_r;
  assign poll_done = pdone_r;
endmodule
`default_nettype wire

// file: ibh_device.sv
// Device end: address recognition, source and acceptor handshakes, polling.
//
// Overview of operation
// - Open-collector source settles two microseconds before valid.
// - Three-state drivers allow shorter settling times.
// - Attention change handled within two hundred nanoseconds.
// - Clear or remote-off unaddresses within hundred microseconds.
// - Acceptor takes nonzero time to accept commands.
// - Each handshake step waits for previous step.
// - Slowest acceptor paces every byte transfer.
// - Activate talker or listener only on address match.
// - Accept all controller commands while attention true.
// - Host loads the bus address before transfers.
// - Handshake pins are positive-logic complements.
// - Attention with end drives poll response byte.
// - System clock steps all interface state machines.
`timescale 1ns/100ps
`default_nettype none
module ibh_dev
  import ibh_pkg::*;
#(
  parameter ibh_drv_e DRV_KIND = IBH_DRV_OPEN
)(
  // Clock and reset
  input  wire logic              clock,
  input  wire logic              rst_n,
  // Bus
  ibh_if.device                  bus,
  // Configuration from the host
  input  wire logic [ADDR_W-1:0] my_addr,
  input  wire logic [7:0]        poll_resp,
  // Transmit
  input  wire logic              tx_valid,
  input  wire logic [7:0]        tx_byte,
  input  wire logic              tx_eoi,
  output logic                   tx_ready,
  // Receive
  output logic [7:0]             rx_byte,
  output logic                   rx_strobe,
  output logic                   rx_is_cmd,
  // State
  output logic                   talk_active,
  output logic                   listen_active
);
  typedef enum logic [1:0] {IBH_S_IDLE, IBH_S_SETTLE, IBH_S_VALID, IBH_S_WAIT} ibh_sst_e;
  typedef enum logic [1:0] {IBH_A_IDLE, IBH_A_READY, IBH_A_TAKE, IBH_A_DONE} ibh_ast_e;
  ibh_sst_e            sst_r;
  ibh_ast_e            ast_r;
  logic [SETTLE_W-1:0] cnt_r;
  logic [7:0]          dout_r, rx_r;
  logic                oe_r, valid_r, eoi_r, rdy_r, acc_r, rx_st_r, rx_cmd_r;
  logic                talk_r, listen_r, fast_r, tx_ready_r;
  logic                atn_q_r;
  // Settling time for the first byte after attention and the rest.
  function automatic logic [SETTLE_W-1:0] settle_cyc(input ibh_drv_e kind, input logic fast);
    if (kind == IBH_DRV_OPEN)
      settle_cyc = SETTLE_W'(SETTLE_OPEN_CYC);
    else if (fast)
      settle_cyc = SETTLE_W'(SETTLE_FAST_CYC);
    else if (kind == IBH_DRV_TRI_ATN)
      settle_cyc = SETTLE_W'(SETTLE_TRI_ATN_CYC);
    else
      settle_cyc = SETTLE_W'(SETTLE_TRI_CYC);
  endfunction
  // Attention is read combinationally so the device turns round in one cycle.
  wire       atn      = bus.ctl_atn_o;
  wire       ppoll    = atn & bus.bus_eoi;
  wire [2:0] grp      = bus.bus_data[7:5];
  wire [4:0] addr     = bus.bus_data[ADDR_LSB +: ADDR_W];
  wire       cmd_take = atn & (ast_r == IBH_A_TAKE);
  wire       lad_me   = cmd_take & (grp == GRP_LISTEN) & (addr == my_addr);
  wire       unl      = cmd_take & (grp == GRP_LISTEN) & (addr == ADDR_UN);
  wire       tad_any  = cmd_take & (grp == GRP_TALK);
  wire       tad_me   = tad_any & (addr == my_addr);
  wire       clr      = bus.ctl_ifc_o | ~bus.ctl_ren_o;
  wire       src_on   = talk_r & ~atn;
  wire       acc_on   = atn | listen_r;
  wire       settled  = (cnt_r >= settle_cyc(DRV_KIND, fast_r) - 1'b1);
  // Talker and listener state, cleared at once by clear or by remote going false.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      talk_r <= 1'b0;
      listen_r <= 1'b0;
      atn_q_r <= 1'b0;
      fast_r <= 1'b0;
    end
    else
    begin
      atn_q_r <= atn;
      if (clr)
      begin
        talk_r <= 1'b0;
        listen_r <= 1'b0;
      end
      else
      begin
        if (lad_me)
          listen_r <= 1'b1;
        else if (unl)
          listen_r <= 1'b0;
        if (tad_any)
          talk_r <= tad_me;
      end
      if (atn)
        fast_r <= 1'b0;
      else if (sst_r == IBH_S_WAIT && !bus.bus_accepted && atn_q_r == 1'b0)
        fast_r <= 1'b1;
    end
  end
  // Source handshake.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sst_r <= IBH_S_IDLE;
      cnt_r <= '0;
      dout_r <= 8'h00;
      oe_r <= 1'b0;
      valid_r <= 1'b0;
      eoi_r <= 1'b0;
      tx_ready_r <= 1'b0;
    end
    else if (ppoll)
    begin
      dout_r <= poll_resp;
      oe_r <= 1'b1;
      valid_r <= 1'b0;
      eoi_r <= 1'b0;
      sst_r <= IBH_S_IDLE;
      tx_ready_r <= 1'b0;
    end
    else if (!src_on)
    begin
      oe_r <= 1'b0;
      valid_r <= 1'b0;
      eoi_r <= 1'b0;
      sst_r <= IBH_S_IDLE;
      tx_ready_r <= 1'b0;
    end
    else
    begin
      tx_ready_r <= (sst_r == IBH_S_IDLE) & ~tx_ready_r;
      unique case (sst_r)
        IBH_S_IDLE:
        begin
          cnt_r <= '0;
          oe_r <= 1'b0;
          if (tx_valid && tx_ready_r)
          begin
            dout_r <= tx_byte;
            eoi_r <= tx_eoi;
            oe_r <= 1'b1;
            sst_r <= IBH_S_SETTLE;
          end
        end
        IBH_S_SETTLE:
        begin
          if (!settled)
            cnt_r <= cnt_r + 1'b1;
          else if (bus.bus_ready && !bus.bus_accepted)
          begin
            valid_r <= 1'b1;
            sst_r <= IBH_S_VALID;
          end
        end
        IBH_S_VALID:
          if (bus.bus_accepted)
          begin
            valid_r <= 1'b0;
            sst_r <= IBH_S_WAIT;
          end
        IBH_S_WAIT:
          if (!bus.bus_accepted)
          begin
            eoi_r <= 1'b0;
            sst_r <= IBH_S_IDLE;
          end
      endcase
    end
  end
  // Acceptor handshake.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ast_r <= IBH_A_IDLE;
      rdy_r <= 1'b1;
      acc_r <= 1'b1;
      rx_r <= 8'h00;
      rx_st_r <= 1'b0;
      rx_cmd_r <= 1'b0;
    end
    else
    begin
      rx_st_r <= 1'b0;
      if (!acc_on)
      begin
        ast_r <= IBH_A_IDLE;
        rdy_r <= 1'b1;
        acc_r <= 1'b1;
      end
      else
        unique case (ast_r)
          IBH_A_IDLE:
            if (!bus.bus_valid)
            begin
              rdy_r <= 1'b1;
              acc_r <= 1'b0;
              ast_r <= IBH_A_READY;
            end
          IBH_A_READY:
            if (bus.bus_valid)
            begin
              rdy_r <= 1'b0;
              rx_r <= bus.bus_data;
              ast_r <= IBH_A_TAKE;
            end
          // One cycle spent decoding keeps the acceptance time nonzero.
          IBH_A_TAKE:
          begin
            acc_r <= 1'b1;
            rx_st_r <= 1'b1;
            rx_cmd_r <= atn;
            ast_r <= IBH_A_DONE;
          end
          IBH_A_DONE:
            if (!bus.bus_valid)
              ast_r <= IBH_A_IDLE;
        endcase
    end
  end
  // Negative-logic bus lines are shown here as their positive complements.
  assign bus.dev_data_o     = dout_r;
  assign bus.dev_data_oe    = oe_r;
  assign bus.dev_valid_o    = valid_r;
  assign bus.dev_ready_o    = rdy_r;
  assign bus.dev_accepted_o = acc_r;
  assign bus.dev_eoi_o      = eoi_r;
  assign tx_ready      = tx_ready_r;
  assign rx_byte       = rx_r;
  assign rx_strobe     = rx_st_r;
  assign rx_is_cmd     = rx_cmd_r;
  assign talk_active   = talk_r;
  assign listen_active = listen_r;
endmodule
`default_nettype wire

// file: ibh_checker.sv
// Checker for the instrument bus handshake wires.
`timescale 1ns/100ps
`default_nettype none
module ibh_checker
  import ibh_pkg::*;
(
  // Clock and reset
  input wire logic       clock,
  input wire logic       rst_n,
  // Device drive
  input wire logic [7:0] dev_data_o,
  input wire logic       dev_data_oe,
  input wire logic       dev_valid_o,
  input wire logic       dev_ready_o,
  input wire logic       dev_accepted_o,
  // Resolved bus and management
  input wire logic       bus_valid,
  input wire logic       bus_ready,
  input wire logic       bus_accepted,
  input wire logic       ctl_atn_o,
  input wire logic       ctl_eoi_o,
  input wire logic       ctl_ifc_o,
  input wire logic       ctl_ren_o
);
  localparam int ATN_MAX = 10;
  logic [7:0] prev_r;
  logic [7:0] held_r;
  // Edges the driven byte stayed put; saturates so a long idle cannot wrap.
  always_ff @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prev_r <= 8'h00;
      held_r <= 8'h00;
    end
    else
    begin
      prev_r <= dev_data_o;
      held_r <= (!dev_data_oe || dev_data_o != prev_r) ? 8'h00 :
                (held_r == 8'hFF) ? held_r : held_r + 8'h01;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence s_poll_up;
    $rose(ctl_atn_o && ctl_eoi_o);
  endsequence
  a_settle_time: assert property ($rose(dev_valid_o) |-> held_r >= SETTLE_OPEN_CYC - 1)
    else $error("valid rose before data settled");
  a_wait_acceptors: assert property ($rose(dev_valid_o) |->
    $past(bus_ready && !bus_accepted))
    else $error("valid rose before all acceptors ready");
  a_valid_holds: assert property ($fell(dev_valid_o) |->
    $past(bus_accepted || ctl_atn_o || ctl_ifc_o || !ctl_ren_o))
    else $error("valid dropped before acceptance");
  a_data_holds: assert property (dev_valid_o && $past(dev_valid_o) |-> $stable(dev_data_o))
    else $error("data moved while valid");
  a_ready_drop: assert property ($fell(dev_ready_o) |-> $past(bus_valid))
    else $error("ready dropped without valid");
  a_atn_stops_src: assert property ($rose(ctl_atn_o) |-> ##[0:ATN_MAX] !dev_valid_o)
    else $error("source slow to yield to attention");
  a_poll_drive: assert property (s_poll_up |-> ##[1:ATN_MAX] dev_data_oe)
    else $error("poll response not driven in time");
  a_ifc_quiet: assert property ($rose(ctl_ifc_o) |-> ##[1:4] !dev_valid_o)
    else $error("source active after clear");
  a_reset_idle: assert property (!$past(rst_n) |->
    !dev_valid_o && dev_ready_o && dev_accepted_o && !dev_data_oe)
    else $error("lines not idle after reset");
endmodule
`default_nettype wire

// file: test_instrument_bus_handshake_timing.sv
// Testbench joining the device and controller ends over the bus interface.
`timescale 1ns/100ps
`default_nettype none
`define chk(got, exp, msg) begin compares++; if ((got) !== (exp)) begin n_errors++; \
  $display("wrong value at %0t: %s", $time, msg); end end
module test_instrument_bus_handshake_timing
  import ibh_pkg::*;
;
  int         n_errors  = 0;
  int         compares  = 0;
  int         cycles    = 0;
  int         d_n       = 0;
  int         c_n       = 0;
  logic [7:0] d_last;
  logic       d_cmd;
  logic [7:0] c_last;
  logic       clock     = 1'b0;
  logic       rst_n     = 1'b0;
  logic       send_req  = 1'b0;
  logic [7:0] send_byte = 8'h00;
  logic       send_atn  = 1'b0;
  logic       send_eoi  = 1'b0;
  logic       send_busy;
  logic       rx_enable = 1'b1;
  logic [7:0] c_rx_byte;
  logic       c_rx_strobe;
  logic       ifc_level = 1'b0;
  logic       ren_level = 1'b0;
  logic       poll_req  = 1'b0;
  logic [7:0] poll_byte;
  logic       poll_done;
  logic [4:0] my_addr   = 5'h05;
  logic [7:0] poll_resp = 8'h81;
  logic       tx_valid  = 1'b0;
  logic [7:0] tx_byte   = 8'h00;
  logic       tx_ready;
  logic [7:0] d_rx_byte;
  logic       d_rx_strobe;
  logic       d_rx_is_cmd;
  logic       talk_active;
  logic       listen_active;
  always #10 clock = ~clock;
  ibh_if bus_if ();
  ibh_dev u_ibh_dev (.clock(clock), .rst_n(rst_n), .bus(bus_if), .my_addr(my_addr),
    .poll_resp(poll_resp), .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_eoi(1'b0),
    .tx_ready(tx_ready), .rx_byte(d_rx_byte), .rx_strobe(d_rx_strobe),
    .rx_is_cmd(d_rx_is_cmd), .talk_active(talk_active), .listen_active(listen_active));
  ibh_ctl u_ibh_ctl (.clock(clock), .rst_n(rst_n), .bus(bus_if), .send_req(send_req),
    .send_byte(send_byte), .send_atn(send_atn), .send_eoi(send_eoi), .send_busy(send_busy),
    .rx_enable(rx_enable), .rx_byte(c_rx_byte), .rx_strobe(c_rx_strobe),
    .ifc_level(ifc_level), .ren_level(ren_level), .poll_req(poll_req),
    .poll_byte(poll_byte), .poll_done(poll_done));
  ibh_checker u_ibh_checker (.clock(clock), .rst_n(rst_n), .dev_data_o(bus_if.dev_data_o),
    .dev_data_oe(bus_if.dev_data_oe), .dev_valid_o(bus_if.dev_valid_o),
    .dev_ready_o(bus_if.dev_ready_o), .dev_accepted_o(bus_if.dev_accepted_o),
    .bus_valid(bus_if.bus_valid), .bus_ready(bus_if.bus_ready),
    .bus_accepted(bus_if.bus_accepted), .ctl_atn_o(bus_if.ctl_atn_o),
    .ctl_eoi_o(bus_if.ctl_eoi_o), .ctl_ifc_o(bus_if.ctl_ifc_o),
    .ctl_ren_o(bus_if.ctl_ren_o));
  task automatic wrap_up();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Strobes last one cycle, so they are caught on every edge rather than polled.
  always @(posedge clock)
  begin
    cycles++;
    if (d_rx_strobe === 1'b1)
    begin
      d_n++;
      d_last = d_rx_byte;
      d_cmd  = d_rx_is_cmd;
    end
    if (c_rx_strobe === 1'b1)
    begin
      c_n++;
      c_last = c_rx_byte;
    end
    if (cycles == 20000)
    begin
      n_errors++;
      wrap_up();
    end
  end
  task automatic send(input logic [7:0] b, input logic atn);
    int k;
    @(negedge clock);
    send_req  = 1'b1;
    send_byte = b;
    send_atn  = atn;
    @(negedge clock);
    send_req = 1'b0;
    for (k = 0; k < 2000 && send_busy !== 1'b0; k++)
      @(negedge clock);
    `chk(send_busy, 1'b0, "send hung")
    repeat (4) @(negedge clock);
  endtask
  task automatic put_tx(input logic [7:0] b, output int k);
    @(negedge clock);
    tx_valid = 1'b1;
    tx_byte  = b;
    for (k = 0; k < 500 && tx_ready !== 1'b1; k++)
      @(negedge clock);
    @(negedge clock);
    tx_valid = 1'b0;
    for (k = 1; k < 500 && bus_if.bus_valid !== 1'b1 && rx_enable; k++)
      @(negedge clock);
  endtask
  task automatic wait_ctl(input int n0);
    for (int k = 0; k < 1000 && c_n == n0; k++)
      @(negedge clock);
  endtask
  task automatic t_reset();
    `chk(bus_if.dev_valid_o, 1'b0, "valid after reset")
    `chk(bus_if.dev_ready_o, 1'b1, "ready after reset")
    `chk(bus_if.dev_accepted_o, 1'b1, "accepted after reset")
    `chk(bus_if.dev_data_oe, 1'b0, "drive after reset")
  endtask
  task automatic t_listen();
    int n0;
    send({GRP_LISTEN, my_addr ^ 5'h01}, 1'b1);
    `chk(listen_active, 1'b0, "listen on foreign address")
    send({GRP_LISTEN, my_addr}, 1'b1);
    `chk(listen_active, 1'b1, "no listen on own address")
    n0 = d_n;
    send(8'h14, 1'b1);
    `chk(d_n - n0, 1, "command not taken")
    `chk(d_cmd, 1'b1, "command flag")
    send(8'h5A, 1'b0);
    `chk(d_last, 8'h5A, "first data byte")
    `chk(d_cmd, 1'b0, "data flagged as command")
    send(8'hA5, 1'b0);
    `chk(d_last, 8'hA5, "back to back byte")
    send({GRP_LISTEN, ADDR_UN}, 1'b1);
    `chk(listen_active, 1'b0, "unlisten ignored")
  endtask
  task automatic t_talk();
    int k;
    int n0;
    @(negedge clock);
    rx_enable = 1'b0;
    send({GRP_TALK, my_addr}, 1'b1);
    `chk(talk_active, 1'b1, "no talk on own address")
    n0 = c_n;
    put_tx(8'hC3, k);
    repeat (300) @(negedge clock);
    `chk(bus_if.bus_valid, 1'b0, "valid while acceptor not ready")
    rx_enable = 1'b1;
    wait_ctl(n0);
    `chk(c_last, 8'hC3, "held byte")
    n0 = c_n;
    put_tx(8'h3C, k);
    `chk(k >= SETTLE_OPEN_CYC - 1, 1'b1, "settling too short")
    wait_ctl(n0);
    `chk(c_last, 8'h3C, "second byte")
    send({GRP_TALK, my_addr ^ 5'h01}, 1'b1);
    `chk(talk_active, 1'b0, "talk kept after other talker")
  endtask
  task automatic t_poll();
    int k;
    @(negedge clock);
    poll_req = 1'b1;
    @(negedge clock);
    poll_req = 1'b0;
    for (k = 0; k < 50 && poll_done !== 1'b1; k++)
      @(negedge clock);
    `chk(poll_byte, poll_resp, "poll response")
  endtask
  task automatic t_clear();
    send({GRP_LISTEN, my_addr}, 1'b1);
    `chk(listen_active, 1'b1, "not listening before clear")
    ifc_level = 1'b1;
    repeat (5) @(negedge clock);
    `chk(listen_active, 1'b0, "listen kept through clear")
    ifc_level = 1'b0;
    send({GRP_LISTEN, my_addr}, 1'b1);
    `chk(listen_active, 1'b1, "not listening before remote off")
    ren_level = 1'b0;
    repeat (5) @(negedge clock);
    `chk(listen_active, 1'b0, "listen kept with remote off")
    ren_level = 1'b1;
  endtask
  initial
  begin
    repeat (20) @(negedge clock);
    rst_n = 1'b1;
    t_reset();
    ren_level = 1'b1;
    repeat (4) @(negedge clock);
    t_listen();
    t_talk();
    t_poll();
    t_clear();
    wrap_up();
  end
endmodule
`default_nettype wire
